/* hw/dlt_pkg.sv */
// Constants shared by the debug link time-out and tagging block
// Operation
// RULE1: A tag follows its word through the queue; tagged head enters debug state.
// RULE2: Entering the background debug state switches tagging off.
// RULE3: Serial debug commands are ignored while tagging is active.
// RULE4: Tag-and-go turns the strobe pin and debug pin into tag inputs.
// RULE5: Tag pins are active low, sampled at external bus clock fall.
// RULE6: Each tag pin tags its own byte independently; both low tags both.
// RULE7: High tagging always allowed; low tagging only with low strobe enabled.
// RULE8: Debug pin held low over 128 cycles is a speed-sync request.
// RULE9: After speed-sync the target waits for a rising edge, without time-out.
// RULE10: Pin high again within 128 cycles is a bit; await next falling edge.
// RULE11: No falling edge within 512 cycles of the last one soft-resets.
// RULE12: Without handshake, read data not fetched in 512 cycles soft-resets.
// RULE13: With handshake, time-out is suspended between read and its acknowledge.
// RULE14: Sending the acknowledge re-arms the 512-cycle time-out.
// RULE15: Host fetches read data within 512 cycles after the acknowledge.
// RULE16: After a time-out the next falling edge starts a command or sync.
// RULE17: A partial command or partial read keeps the time-out active.
// RULE18: Restart from wait soft-resets and turns the handshake off.
// RULE19: Restart from stop soft-resets and turns the handshake off.
// RULE20: Handshake is off after reset; commands switch it on and off.
// RULE21: Tag-and-go never produces an acknowledge pulse.
// RULE22: Speed-sync detection discards partial work like a time-out.
// RULE23: Time-out counter cleared per falling edge, flags soft reset at limit.
`default_nettype none

package dlt_pkg;

	localparam int unsigned SYNC_LOW_CYCLES = 128;
	localparam int unsigned TIMEOUT_CYCLES = 512;
	localparam int unsigned LOW_CNT_W = 9;
	localparam int unsigned GAP_CNT_W = 10;
	localparam int unsigned TAG_QUEUE_DEPTH = 3;
	localparam logic [1:0] TAG_NONE = 2'h0;

	typedef enum logic [1:0] {
		DLT_IDLE,
		DLT_LOW,
		DLT_HIGH,
		DLT_SYNC_WAIT
	} dlt_link_e;

endpackage : dlt_pkg

`default_nettype wire

/* hw/dlt_debug_link.sv */
// Debug pin bit timing, serial time-out, soft reset and instruction tagging
`default_nettype none

module dlt_debug_link #(
	parameter int unsigned QDEPTH = dlt_pkg::TAG_QUEUE_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst,
	// Debug pin level as seen by the target
	input wire logic background_debug_pin,
	// Low byte strobe pin level, low tag input while tagging
	input wire logic low_byte_strobe,
	input wire logic low_strobe_en,
	input wire logic external_bus_clock,
	// Word being read into the instruction queue at this bus clock fall
	input wire logic ifetch,
	input wire logic queue_pop,
	input wire logic queue_flush,
	input wire logic background_debug_state,
	// Pulses from the command decoder, except cmd_partial, which is held as a level
	input wire logic tag_and_go_command,
	input wire logic handshake_on_cmd,
	input wire logic handshake_off_cmd,
	input wire logic read_issue,
	input wire logic read_done,
	input wire logic cmd_partial,
	input wire logic ack_req,
	input wire logic wait_restart,
	input wire logic stop_restart,
	output logic bit_valid,
	output logic bit_low_long,
	output logic sync_req,
	output logic sync_rise,
	output logic soft_reset,
	output logic ack_pulse,
	output logic ack_enabled,
	output logic tagging,
	output logic cmd_enable,
	output logic enter_debug_state,
	output logic [1:0] head_tag
);

	dlt_pkg::dlt_link_e state_q;
	logic pin_prev_q;
	logic external_bus_clock_prev_q;
	logic [dlt_pkg::LOW_CNT_W-1:0] low_cnt_q;
	logic [dlt_pkg::GAP_CNT_W-1:0] gap_cnt_q;
	logic read_pend_q;
	logic ack_seen_q;
	logic ack_en_q;
	logic tag_q;
	logic bdm_prev_q;
	logic soft_q;
	logic bit_q;
	logic sync_q;
	logic rise_q;
	logic ack_q;
	logic enter_q;
	logic [1:0] head_q;
	logic [1:0] tq_q [QDEPTH];
	logic [QDEPTH-1:0] tv_q;
	logic long_q;
	logic cmd_en_q;

	logic fall_edge;
	logic rise_edge;
	logic external_bus_clock_fall;
	logic link_on;
	logic armed;
	logic timeout;
	logic sync_hit;
	logic restart;
	logic bdm_rise;
	logic push;
	logic [1:0] push_tag;
	logic [QDEPTH:0] tail_sel;

	localparam logic [dlt_pkg::LOW_CNT_W-1:0] LOW_LIMIT =
		dlt_pkg::LOW_CNT_W'(dlt_pkg::SYNC_LOW_CYCLES);
	localparam logic [dlt_pkg::GAP_CNT_W-1:0] GAP_LIMIT =
		dlt_pkg::GAP_CNT_W'(dlt_pkg::TIMEOUT_CYCLES);
	localparam logic [dlt_pkg::LOW_CNT_W-1:0] LOW_CNT_W1 = dlt_pkg::LOW_CNT_W'(1);

	// The serial logic is blind while the pin serves as high tag input
	assign link_on = ~tag_q; // RULE3
	assign fall_edge = link_on & pin_prev_q & ~background_debug_pin;
	assign rise_edge = link_on & ~pin_prev_q & background_debug_pin;
	assign external_bus_clock_fall = external_bus_clock_prev_q & ~external_bus_clock; // RULE5
	assign restart = wait_restart | stop_restart; // RULE18 RULE19
	assign bdm_rise = background_debug_state & ~bdm_prev_q;

	// Read waits untimed under handshake until the acknowledge goes out
	assign armed = cmd_partial | (read_pend_q & (~ack_en_q | ack_seen_q)); // RULE12 RULE13 RULE17
	assign timeout = link_on & armed & (state_q != dlt_pkg::DLT_SYNC_WAIT)
		& (gap_cnt_q > GAP_LIMIT) & ~fall_edge; // RULE11 RULE23
	assign sync_hit = link_on & (state_q == dlt_pkg::DLT_LOW)
		& ~background_debug_pin & (low_cnt_q == LOW_LIMIT); // RULE8

	// Pin history resets to its idle high level, so reset gives no false rise
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pin_prev_q <= 1'b1;
		end else begin
			pin_prev_q <= background_debug_pin;
		end
	end

	// Bus clock history resets to its idle low level for the same reason
	always_ff @(posedge core_clk) begin
		if (rst) begin
			external_bus_clock_prev_q <= 1'b0;
		end else begin
			external_bus_clock_prev_q <= external_bus_clock;
		end
	end

	// Debug state history, for its rising edge only
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bdm_prev_q <= 1'b0;
		end else begin
			bdm_prev_q <= background_debug_state;
		end
	end

	// Bit versus speed-sync discrimination
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= dlt_pkg::DLT_IDLE;
			low_cnt_q <= '0;
		end else if (restart || !link_on) begin
			state_q <= dlt_pkg::DLT_IDLE;
			low_cnt_q <= '0;
		end else begin
			unique case (state_q)
				dlt_pkg::DLT_IDLE,
				dlt_pkg::DLT_HIGH: begin
					if (fall_edge) begin // RULE16
						state_q <= dlt_pkg::DLT_LOW;
						low_cnt_q <= LOW_CNT_W1;
					end else if (timeout) begin
						state_q <= dlt_pkg::DLT_IDLE;
					end
				end
				dlt_pkg::DLT_LOW: begin
					if (sync_hit) begin
						state_q <= dlt_pkg::DLT_SYNC_WAIT; // RULE9
					end else if (rise_edge) begin
						state_q <= dlt_pkg::DLT_HIGH; // RULE10
					end else if (timeout) begin
						state_q <= dlt_pkg::DLT_IDLE;
					end else begin
						low_cnt_q <= low_cnt_q + LOW_CNT_W1;
					end
				end
				dlt_pkg::DLT_SYNC_WAIT: begin
					// No time-out exit; only the rising edge, a restart or tagging leaves
					if (rise_edge) begin // RULE9
						state_q <= dlt_pkg::DLT_IDLE;
					end
				end
			endcase
		end
	end

	// Gap since last falling edge or acknowledge, saturating just above the limit
	always_ff @(posedge core_clk) begin
		if (rst || restart || soft_q) begin
			gap_cnt_q <= '0;
		end else if (fall_edge || ack_q) begin
			gap_cnt_q <= '0; // RULE14 RULE23
		end else if (gap_cnt_q <= GAP_LIMIT) begin
			gap_cnt_q <= gap_cnt_q + dlt_pkg::GAP_CNT_W'(1);
		end
	end

	// Outstanding read and whether its acknowledge has been sent
	always_ff @(posedge core_clk) begin
		if (rst || restart || soft_q || timeout || sync_hit) begin
			read_pend_q <= 1'b0;
			ack_seen_q <= 1'b0;
		end else if (read_issue) begin
			read_pend_q <= 1'b1;
			ack_seen_q <= 1'b0;
		end else if (read_done) begin
			read_pend_q <= 1'b0;
			ack_seen_q <= 1'b0;
		end else if (ack_q) begin
			ack_seen_q <= read_pend_q; // RULE14
		end
	end

	// Handshake enable
	always_ff @(posedge core_clk) begin
		if (rst || restart) begin
			ack_en_q <= 1'b0; // RULE20 RULE18 RULE19
		end else if (handshake_on_cmd) begin
			ack_en_q <= 1'b1; // RULE20
		end else if (handshake_off_cmd) begin
			ack_en_q <= 1'b0;
		end
	end

	// Acknowledge pulse is withheld for tag-and-go and while tagging
	always_ff @(posedge core_clk) begin
		if (rst || restart) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= ack_req & ack_en_q & ~tag_q & ~tag_and_go_command; // RULE21
		end
	end

	// Soft reset from every cause that discards partial work
	always_ff @(posedge core_clk) begin
		if (rst) begin
			soft_q <= 1'b0;
		end else begin
			soft_q <= timeout | sync_hit | restart; // RULE11 RULE22 RULE18 RULE19
		end
	end

	// One-cycle timing event pulses; a clock restart swallows them
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bit_q <= 1'b0;
			sync_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			bit_q <= rise_edge & (state_q == dlt_pkg::DLT_LOW) & ~restart; // RULE10
			sync_q <= sync_hit & ~restart; // RULE8
			rise_q <= rise_edge & (state_q == dlt_pkg::DLT_SYNC_WAIT) & ~restart;
		end
	end

	// Level while the pin has been held low past a bit and the rise is awaited
	always_ff @(posedge core_clk) begin
		if (rst || restart || !link_on) begin
			long_q <= 1'b0;
		end else if (sync_hit) begin
			long_q <= 1'b1; // RULE8 RULE9
		end else if (rise_edge) begin
			long_q <= 1'b0; // RULE9
		end
	end

	// Tagging mode; entering debug state wins over a simultaneous tag-and-go
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tag_q <= 1'b0;
		end else if (bdm_rise) begin
			tag_q <= 1'b0; // RULE2
		end else if (tag_and_go_command) begin
			tag_q <= 1'b1; // RULE4
		end
	end

	// Tag capture: bit 1 high byte, bit 0 low byte, each independent
	assign push = external_bus_clock_fall & ifetch;
	assign push_tag = {tag_q & ~background_debug_pin,
		tag_q & low_strobe_en & ~low_byte_strobe}; // RULE4 RULE5 RULE6 RULE7

	// One-hot tail position after an optional pop
	always_comb begin
		tail_sel = '0;
		for (int i = 0; i < QDEPTH; i++) begin
			if (!tv_q[i] && (i == 0 || tv_q[i-1])) begin
				tail_sel[i] = 1'b1;
			end
		end
		if (&tv_q) begin
			tail_sel[QDEPTH] = 1'b1;
		end
		if (queue_pop && tv_q[0]) begin
			tail_sel = tail_sel >> 1;
		end
	end

	// Tag queue mirrors the instruction queue; a push when full is dropped unless a pop comes in the same cycle
	genvar g;
	generate
		for (g = 0; g < QDEPTH; g++) begin : g_tq
			logic nxt_v;
			logic [1:0] nxt_t;
			if (g == QDEPTH - 1) begin : g_last
				assign nxt_v = 1'b0;
				assign nxt_t = dlt_pkg::TAG_NONE;
			end else begin : g_mid
				assign nxt_v = tv_q[g+1];
				assign nxt_t = tq_q[g+1];
			end
			always_ff @(posedge core_clk) begin
				if (rst || queue_flush) begin
					tv_q[g] <= 1'b0;
					tq_q[g] <= dlt_pkg::TAG_NONE;
				end else if (push && tail_sel[g]) begin
					tv_q[g] <= 1'b1;
					tq_q[g] <= push_tag; // RULE1
				end else if (queue_pop && tv_q[0]) begin
					tv_q[g] <= nxt_v;
					tq_q[g] <= nxt_t; // RULE1
				end
			end
		end
	endgenerate

	// Tagged word at the head diverts to the debug state instead of executing
	always_ff @(posedge core_clk) begin
		if (rst || queue_flush) begin
			enter_q <= 1'b0;
		end else begin
			enter_q <= tv_q[0] & (|tq_q[0]) & ~background_debug_state; // RULE1
		end
	end

	// Tag of the word about to execute, none when the queue is empty
	always_ff @(posedge core_clk) begin
		if (rst || queue_flush) begin
			head_q <= dlt_pkg::TAG_NONE;
		end else begin
			head_q <= tv_q[0] ? tq_q[0] : dlt_pkg::TAG_NONE;
		end
	end

	// Commands close at the same edge at which tagging opens
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cmd_en_q <= 1'b1;
		end else begin
			cmd_en_q <= ~(tag_q | tag_and_go_command); // RULE3
		end
	end

	assign bit_valid = bit_q;
	assign bit_low_long = long_q;
	assign sync_req = sync_q;
	assign sync_rise = rise_q;
	assign soft_reset = soft_q;
	assign ack_pulse = ack_q;
	assign ack_enabled = ack_en_q;
	assign tagging = tag_q;
	assign cmd_enable = cmd_en_q;
	assign enter_debug_state = enter_q;
	assign head_tag = head_q;

endmodule : dlt_debug_link

`default_nettype wire

/* sim/dlt_debug_link_asserts.sv */
// Concurrent checks on the debug link block ports
`default_nettype none
module dlt_debug_link_asserts (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic background_debug_pin,
	input wire logic tag_and_go_command,
	input wire logic handshake_on_cmd,
	input wire logic handshake_off_cmd,
	input wire logic ack_req,
	input wire logic wait_restart,
	input wire logic stop_restart,
	input wire logic background_debug_state,
	input wire logic bit_valid,
	input wire logic sync_req,
	input wire logic soft_reset,
	input wire logic ack_pulse,
	input wire logic ack_enabled,
	input wire logic tagging,
	input wire logic cmd_enable
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	restart_soft_a: assert property ((wait_restart || stop_restart) |=> soft_reset)
		else $error("restart gave no soft reset");
	restart_ack_a: assert property ((wait_restart || stop_restart) |=> !ack_enabled)
		else $error("handshake on after restart");
	ack_gate_a: assert property (ack_pulse |->
		$past(ack_req && ack_enabled && !tagging && !tag_and_go_command))
		else $error("acknowledge without cause");
	ack_make_a: assert property (ack_req && ack_enabled && !tagging && !tag_and_go_command |=> ack_pulse)
		else $error("acknowledge missing");
	tag_cmd_a: assert property (tagging |-> !cmd_enable)
		else $error("commands open while tagging");
	debug_untag_a: assert property (background_debug_state |=> !tagging)
		else $error("tagging kept in debug state");
	tag_on_a: assert property (tag_and_go_command && !background_debug_state |=> tagging)
		else $error("tag-and-go did not tag");
	hs_on_a: assert property (handshake_on_cmd && !handshake_off_cmd && !wait_restart
		&& !stop_restart |=> ack_enabled)
		else $error("handshake not switched on");
	sync_soft_a: assert property (sync_req |-> ##[0:1] soft_reset)
		else $error("sync kept partial work");
	bit_end_a: assert property (bit_valid |-> $past(background_debug_pin) && !sync_req)
		else $error("bit ended while pin low");
	cover property (sync_req);
	cover property (ack_pulse);
	cover property (bit_valid);
endmodule : dlt_debug_link_asserts

bind dlt_debug_link dlt_debug_link_asserts dlt_debug_link_asserts_inst (.*);
`default_nettype wire

/* sim/dlt_host_pod.sv */
// Behavioural host pod driving the debug pin
`default_nettype none
module dlt_host_pod (
	input wire logic core_clk,
	output var logic pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// Pin idles high through its pull-up
	initial pin = 1'h1;
	// Each transmission opens with a falling edge; long lows ask for sync
	task automatic drive_low(input int cyc);
		@(posedge core_clk) #1 pin = 1'h0;
		repeat (cyc) @(posedge core_clk);
		#1 pin = 1'h1;
	endtask : drive_low
	task automatic set_level(input logic v);
		@(posedge core_clk) #1 pin = v;
	endtask : set_level
endmodule : dlt_host_pod
`default_nettype wire

/* sim/dlt_debug_link_tb.sv */
// Self-checking bench for the debug link block
`default_nettype none
module dlt_debug_link_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'h0;
	logic rst, lbs, lse, ebc, ifetch, bds, part;
	logic [9:0] cmd;
	logic bit_valid, sync_req, sync_rise, soft_reset, ack_pulse, ack_en, tagging, cmd_en, edbg;
	logic blong;
	logic [1:0] head_tag;
	wire logic pin;
	wire logic [5:0] obs = {edbg, ack_pulse, soft_reset, sync_rise, sync_req, bit_valid};
	int num_errors = 0, n_compared = 0, n;
	dlt_host_pod dlt_host_pod_inst (.core_clk(core_clk), .pin(pin));
	dlt_debug_link dlt_debug_link_inst (.core_clk(core_clk), .rst(rst),
		.background_debug_pin(pin), .low_byte_strobe(lbs), .low_strobe_en(lse),
		.external_bus_clock(ebc), .ifetch(ifetch), .queue_pop(cmd[8]), .queue_flush(cmd[9]),
		.background_debug_state(bds), .tag_and_go_command(cmd[0]), .handshake_on_cmd(cmd[1]),
		.handshake_off_cmd(cmd[2]), .read_issue(cmd[3]), .read_done(cmd[4]),
		.cmd_partial(part), .ack_req(cmd[5]), .wait_restart(cmd[6]), .stop_restart(cmd[7]),
		.bit_valid(bit_valid), .bit_low_long(blong), .sync_req(sync_req), .sync_rise(sync_rise),
		.soft_reset(soft_reset), .ack_pulse(ack_pulse), .ack_enabled(ack_en),
		.tagging(tagging), .cmd_enable(cmd_en), .enter_debug_state(edbg), .head_tag(head_tag));
	always #5 core_clk = ~core_clk;
	task automatic end_of_test;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	task automatic chk(input bit ok, input string msg);
		n_compared++;
		if (!ok) begin
			$display("CHECK FAILED at %0t: %s", $time, msg);
			num_errors++;
		end
	endtask : chk
	// Counts edges until output k shows; a bound that runs out ends the run when needed
	task automatic wait_sig(input int k, input int lim, input bit need);
		n = 0;
		#1;
		while (obs[k] !== 1'h1 && n < lim) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (need && n >= lim) begin
			chk(0, "wait ran out");
			end_of_test();
		end
	endtask : wait_sig
	task automatic pulse(input int k);
		@(posedge core_clk) #1 cmd[k] = 1'h1;
		@(posedge core_clk) #1 cmd[k] = 1'h0;
	endtask : pulse
	task automatic t_link;
		chk(ack_en === 1'h0 && tagging === 1'h0 && cmd_en === 1'h1, "reset state");
		dlt_host_pod_inst.drive_low(20);
		wait_sig(0, 4, 1);
		dlt_host_pod_inst.set_level(1'h0);
		wait_sig(1, 140, 1);
		chk(n > 126 && n < 132, "sync length");
		wait_sig(2, 1000, 0);
		chk(n == 1000, "sync wait ended");
		chk(blong === 1'h1, "long low not shown in sync wait");
		dlt_host_pod_inst.set_level(1'h1);
		wait_sig(2, 4, 1);
		chk(blong === 1'h0, "long low kept after rise");
	endtask : t_link
	task automatic t_timeout;
		part = 1'h1;
		dlt_host_pod_inst.drive_low(5);
		wait_sig(3, 600, 1);
		chk(n > 504 && n < 515, "partial time-out");
		part = 1'h0;
		dlt_host_pod_inst.drive_low(20);
		wait_sig(0, 4, 1);
		pulse(3);
		wait_sig(3, 600, 1);
		// The window runs from the read's last falling edge, 22 edges before the wait
		chk(n > 488 && n < 496, "read time-out");
	endtask : t_timeout
	task automatic t_handshake;
		pulse(1);
		dlt_host_pod_inst.drive_low(2);
		pulse(3);
		wait_sig(3, 800, 0);
		chk(n == 800, "read timed out with handshake");
		pulse(5);
		wait_sig(4, 3, 1);
		wait_sig(3, 600, 1);
		chk(n > 505 && n < 518, "re-armed time-out");
		pulse(3);
		pulse(5);
		pulse(4);
		wait_sig(3, 700, 0);
		chk(n == 700, "fetched read timed out");
		for (int k = 6; k < 8; k++) begin
			pulse(1);
			chk(ack_en === 1'h1, "handshake on");
			pulse(k);
			chk(ack_en === 1'h0, "handshake after restart");
		end
		pulse(1);
		pulse(2);
		chk(ack_en === 1'h0, "handshake not switched off");
	endtask : t_handshake
	task automatic t_tags;
		logic [2:0] tbl [5] = '{3'h7, 3'h5, 3'h3, 3'h1, 3'h0};
		logic [1:0] exp;
		pulse(1);
		pulse(0);
		chk(tagging === 1'h1 && cmd_en === 1'h0, "tag mode");
		pulse(5);
		wait_sig(4, 4, 0);
		chk(n == 4, "acknowledge while tagging");
		for (int i = 0; i < 5; i++) begin
			exp = {~tbl[i][2], ~tbl[i][1] & tbl[i][0]};
			pulse(9);
			dlt_host_pod_inst.set_level(tbl[i][2]);
			lbs = tbl[i][1];
			lse = tbl[i][0];
			ifetch = 1'h1;
			ebc = 1'h1;
			@(posedge core_clk) #1 ebc = 1'h0;
			repeat (2) @(posedge core_clk);
			#1 ifetch = 1'h0;
			wait_sig(5, 6, 0);
			chk(head_tag === exp, "tag bytes");
			chk(edbg === (exp != 2'h0), "debug entry");
		end
		dlt_host_pod_inst.set_level(1'h1);
		lse = 1'h1;
		ifetch = 1'h1;
		ebc = 1'h1;
		@(posedge core_clk) #1 ebc = 1'h0;
		@(posedge core_clk) #1 ifetch = 1'h0;
		pulse(8);
		@(posedge core_clk) #1;
		chk(head_tag === 2'h1 && edbg === 1'h1, "tag did not follow queue");
		lbs = 1'h1;
		bds = 1'h1;
		@(posedge core_clk) #1 bds = 1'h0;
		chk(tagging === 1'h0, "tagging after debug entry");
	endtask : t_tags
	initial begin
		rst = 1'h1;
		lbs = 1'h1;
		lse = 1'h0;
		ebc = 1'h0;
		ifetch = 1'h0;
		bds = 1'h0;
		part = 1'h0;
		cmd = '0;
		repeat (2) @(posedge core_clk);
		#1 rst = 1'h0;
		t_link();
		t_timeout();
		t_handshake();
		t_tags();
		end_of_test();
	end
endmodule : dlt_debug_link_tb
`default_nettype wire
